// ==== design/board_glue_pkg.sv ====
// Package holding constants and carrier types for the board control glue
package board_glue_pkg;
    // Clock rate and watchdog timeout
    localparam int unsigned CLOCK_HZ        = 200_000_000;
    localparam int unsigned TIMEOUT_MS      = 1600;
    localparam int unsigned TIMEOUT_CYCLES  = (CLOCK_HZ / 1000) * TIMEOUT_MS;
    // Length of the low-going reset pulse after expiry
    localparam int unsigned RESET_PULSE_US  = 140;
    localparam int unsigned RESET_PULSE_CYC = (CLOCK_HZ / 1_000_000) * RESET_PULSE_US;
    // Address field positions
    localparam int unsigned DECODE_LSB      = 11;
    localparam int unsigned DECODE_MSB      = 15;
    // Decoder slot codes on address bits 14..11 (bit 15 gates the decoder)
    localparam logic [3:0] SLOT_IO          = 4'h0;
    localparam logic [3:0] SLOT_CONFIG      = 4'h1;
    localparam logic [3:0] SLOT_FILTER_CLK  = 4'h2;
    localparam logic [3:0] SLOT_CHANNEL_LOAD_SELECT_N     = 4'h3;
    localparam logic [3:0] SLOT_GAIN_POT    = 4'h4;
    localparam logic [3:0] SLOT_DC_A        = 4'h5;
    localparam logic [3:0] SLOT_DC_B        = 4'h6;
    localparam logic [3:0] SLOT_TONE_A      = 4'h7;
    localparam logic [3:0] SLOT_TONE_B      = 4'h8;
    localparam logic [3:0] SLOT_NVMEM       = 4'h9;
    localparam int unsigned NUM_SELECTS     = 10;
    // Reset values
    localparam logic [7:0] ADDR_LOW_RESET   = 8'h00;

    // Active-low select bundle
    typedef struct packed {
        logic io_select_n;
        logic config_switch_select_n;
        logic filter_clock_select_n;
        logic channel_load_select_n;
        logic gain_pot_latch_select_n;
        logic dc_current_pair_a_select_n;
        logic dc_current_pair_b_select_n;
        logic tone_group_a_select_n;
        logic tone_group_b_select_n;
        logic nvmem_select_n;
    } selects_s;
endpackage

// ==== design/board_control_glue_watchdog.sv ====
// Board control glue: clock halving, address latch, selects, switches, watchdog
// How it works
// [R1] Flip-flop halves the system clock for tones
// [R2] Low address latched transparently during latch_gate
// [R3] Latched low byte joins high byte
// [R4] Upper five address lines decoded into selects
// [R5] Decoder enabled by NAND of strobe, A15
// [R6] Ten distinct active-low selects produced
// [R7] Barred selects and strobes asserted low
// [R8] Switches driven onto bus on read+select
// [R9] Memory write enable is OR of two lows
// [R10] Processor reads configuration after reset
// [R11] Processor pulses service low periodically
// [R12] Service reaches watchdog only when enabled
// [R13] Qualified service restarts timeout from zero
// [R14] Disabled watchdog never times out
// [R15] Expiry after 1.6 s issues reset pulse
// [R16] Run indicator off while processor in reset
// [R17] Timeout counter reloads on service, expiry resets
module board_control_glue_watchdog #(
    parameter int unsigned TIMEOUT_CYCLES  = board_glue_pkg::TIMEOUT_CYCLES,
    parameter int unsigned RESET_PULSE_CYC = board_glue_pkg::RESET_PULSE_CYC,
    parameter int unsigned SW_WIDTH        = 8
) (
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // Multiplexed bus from the processor
    input  wire logic [7:0]             ad_in,
    input  wire logic [7:0]             addr_high,
    input  wire logic                   latch_gate,
    input  wire logic                   program_store_strobe_n,
    input  wire logic                   read_strobe_n,
    input  wire logic                   write_strobe_n,
    // Data bus drive back toward the processor
    output logic      [SW_WIDTH-1:0]    ad_out,
    output logic                        ad_oe,
    // Board address and selects
    output logic      [15:0]            address,
    output board_glue_pkg::selects_s    selects,
    output logic                        nvmem_write_n,
    // Switches and watchdog
    input  wire logic [SW_WIDTH-1:0]    config_switches,
    input  wire logic                   watchdog_off_switch,
    input  wire logic                   watchdog_service_n,
    input  wire logic                   write_permit_n,
    output logic                        watchdog_kick_in,
    output logic                        processor_reset_n,
    output logic                        run_indicator,
    output logic                        tone_half_clock
);

    // Counter widths follow the parameters, so a short timeout costs fewer flops
    localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int unsigned PW = $clog2(RESET_PULSE_CYC + 1);
    // Last count values, reached one cycle before the watchdog acts
    localparam logic [CW-1:0] TIMEOUT_LAST = CW'(TIMEOUT_CYCLES - 1);
    localparam logic [PW-1:0] PULSE_LAST   = PW'(RESET_PULSE_CYC - 1);

    // Watchdog either runs its timeout or drives the reset pulse
    typedef enum logic [0:0] {
        WD_RUN,
        WD_RESET
    } wd_state_e;

    // State of the divider, the address latch and the watchdog
    logic            half_q;       // Divide-by-two stage
    logic            half_d;
    logic [7:0]      addr_low_q;   // Held low address byte
    logic [7:0]      addr_low_d;
    logic [7:0]      addr_low;     // Transparent view of the latch
    logic            decode_en_n;  // Low enables the decoder
    logic [3:0]      slot;         // Decoder input code
    logic [CW-1:0]   count_q;      // Cycles since last service
    logic [CW-1:0]   count_d;
    logic [PW-1:0]   pulse_q;      // Reset pulse length counter
    logic [PW-1:0]   pulse_d;
    wd_state_e       state_q;
    wd_state_e       state_d;
    logic            kick;         // Qualified service pulse

    // Toggle next value of the halving stage
    always_comb begin
        half_d = ~half_q; // R1
    end

    // Trade-off: the half clock leaves as a flop output, never a gated clock
    // Halving flip-flop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            half_q <= 1'b0;
        end else begin
            half_q <= half_d;
        end
    end

    assign tone_half_clock = half_q;

    // Latch follows the bus while the gate is high, else holds
    always_comb begin
        addr_low_d = addr_low_q;
        if (latch_gate) begin
            addr_low_d = ad_in; // R2
        end
    end

    // Trade-off: a flop plus a bypass mux stands in for a level latch
    // Register the held value; the transparent path below covers the open phase
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            addr_low_q <= board_glue_pkg::ADDR_LOW_RESET;
        end else begin
            addr_low_q <= addr_low_d;
        end
    end

    // Every memory sees this address, so the low byte must stay put between strobes
    // Transparency: bus passes straight through while gate is open
    assign addr_low = latch_gate ? ad_in : addr_low_q; // R2
    assign address  = {addr_high, addr_low}; // R3

    // Decoder enable: NAND of strobe activity and top address line
    // The strobe is active low, so the asserted level is inverted first
    assign decode_en_n = ~(~program_store_strobe_n & address[board_glue_pkg::DECODE_MSB]); // R5
    assign slot        = address[board_glue_pkg::DECODE_MSB-1:board_glue_pkg::DECODE_LSB]; // R4

    // Select decode; everything idles high when the decoder is off
    // Codes 10 to 15 stay free for later peripherals
    always_comb begin
        selects = '1; // R7
        if (!decode_en_n) begin
            // Codes without a peripheral leave every select inactive
            if (slot == board_glue_pkg::SLOT_IO) begin
                selects.io_select_n = 1'b0; // R6
            end else if (slot == board_glue_pkg::SLOT_CONFIG) begin
                selects.config_switch_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_FILTER_CLK) begin
                selects.filter_clock_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_CHANNEL_LOAD_SELECT_N) begin
                selects.channel_load_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_GAIN_POT) begin
                selects.gain_pot_latch_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_DC_A) begin
                selects.dc_current_pair_a_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_DC_B) begin
                selects.dc_current_pair_b_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_TONE_A) begin
                selects.tone_group_a_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_TONE_B) begin
                selects.tone_group_b_select_n = 1'b0;
            end else if (slot == board_glue_pkg::SLOT_NVMEM) begin
                selects.nvmem_select_n = 1'b0; // R4
            end
        end
    end

    // Switch buffer drives only for a read of the switch select
    // It must let go for any other read, or it would fight the memories on the bus
    assign ad_oe  = ~(read_strobe_n | selects.config_switch_select_n); // R8
    assign ad_out = ad_oe ? config_switches : '0; // R8

    // Memory write needs both lows; either high blocks it
    // The permit input keeps writes out while the supply is not trusted
    assign nvmem_write_n = write_strobe_n | write_permit_n; // R9

    // Service pulses are short but span whole clocks, so a level view is enough
    // AND of inverted service and inverted switch; stays low when disabled
    assign kick             = ~watchdog_service_n & ~watchdog_off_switch; // R11 R12
    // Kick line follows the qualified pulse; low all the time when disabled
    assign watchdog_kick_in = kick; // R14

    // Watchdog next-state: count, reload on kick, pulse reset on expiry
    // Off switch wins over service and expiry, so a disabled watchdog stays quiet
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        pulse_d = pulse_q;
        case (state_q)
            WD_RUN: begin
                if (watchdog_off_switch) begin
                    count_d = '0; // R14
                end else if (kick) begin
                    count_d = '0; // R13
                end else if (count_q == TIMEOUT_LAST) begin
                    state_d = WD_RESET; // R15
                    count_d = '0;
                    pulse_d = '0;
                end else begin
                    count_d = count_q + CW'(1); // R17
                end
            end
            WD_RESET: begin
                // Pulse length is fixed; service is ignored meanwhile
                if (pulse_q == PULSE_LAST) begin
                    state_d = WD_RUN;
                end else begin
                    pulse_d = pulse_q + PW'(1);
                end
            end
            default: begin
                state_d = WD_RUN;
            end
        endcase
    end

    // Watchdog registers
    // Counter is already zero when the pulse starts, so the next run begins clean
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= WD_RUN;
            count_q <= '0;
            pulse_q <= '0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            pulse_q <= pulse_d;
        end
    end

    // Reset out is low during the pulse; processor then re-reads the switches
    // The latch and the half clock keep running through a watchdog reset
    assign processor_reset_n = rstn & (state_q == WD_RUN); // R15 R10
    // Indicator tracks reset so it goes dark for both reset sources
    assign run_indicator     = processor_reset_n; // R16

    // Halving stage must flip every cycle; the first edge out of reset is skipped
    // because the value sampled there is still the reset value on both sides
    half_toggle_a: assert property (@(posedge clock) disable iff (!rstn) // R1
        $past(rstn) |-> half_q != $past(half_q)) else $error("half clock did not toggle");

    // Latch must hold once gate closes
    latch_hold_a: assert property (@(posedge clock) disable iff (!rstn) // R2
        $fell(latch_gate) ##1 !latch_gate |-> address[7:0] == $past(address[7:0]))
        else $error("low address not held");

    // No select may be low without the decoder enable
    decode_gate_a: assert property (@(posedge clock) disable iff (!rstn) // R5
        decode_en_n |-> selects == '1) else $error("select active while decoder off");

    // At most one select low
    one_select_a: assert property (@(posedge clock) disable iff (!rstn) // R6
        $onehot0(~selects)) else $error("more than one select active");

    // Switch drive needs read and select both low
    switch_drive_a: assert property (@(posedge clock) disable iff (!rstn) // R8
        ad_oe |-> !read_strobe_n && !selects.config_switch_select_n && ad_out == config_switches)
        else $error("switch buffer drive wrong");

    // Write enable low only when both inputs low
    nvmem_write_a: assert property (@(posedge clock) disable iff (!rstn) // R9
        !nvmem_write_n |-> !write_strobe_n && !write_permit_n)
        else $error("memory write without both strobes");

    // Kick restarts count from zero
    kick_reload_a: assert property (@(posedge clock) disable iff (!rstn) // R13
        kick && state_q == WD_RUN |=> count_q == '0) else $error("count not reloaded");

    // Disabled watchdog never enters reset
    wd_disabled_a: assert property (@(posedge clock) disable iff (!rstn) // R14
        watchdog_off_switch && state_q == WD_RUN |-> !watchdog_kick_in ##1 state_q == WD_RUN)
        else $error("disabled watchdog acted");

    // Expiry leads to reset pulse next cycle
    expiry_reset_a: assert property (@(posedge clock) disable iff (!rstn) // R15
        state_q == WD_RUN && count_q == TIMEOUT_LAST && !kick && !watchdog_off_switch
        |=> !processor_reset_n) else $error("expiry without reset pulse");

    // Indicator dark in reset
    run_led_a: assert property (@(posedge clock) disable iff (!rstn) // R16
        state_q == WD_RESET |-> !run_indicator) else $error("run indicator lit in reset");

    // Gate high at an edge loads the held byte from the bus
    latch_capture_a: assert property (@(posedge clock) disable iff (!rstn) // R2
        latch_gate |=> addr_low_q == $past(ad_in)) else $error("low address not captured");

    // Decoder on with the memory slot selects the memory
    nvmem_slot_a: assert property (@(posedge clock) disable iff (!rstn) // R4
        !decode_en_n && slot == board_glue_pkg::SLOT_NVMEM |-> !selects.nvmem_select_n)
        else $error("memory slot not selected");

    // Strobe low with the top line high must open the decoder
    decode_on_a: assert property (@(posedge clock) disable iff (!rstn) // R5
        !program_store_strobe_n && address[board_glue_pkg::DECODE_MSB]
        && slot == board_glue_pkg::SLOT_CONFIG |-> !selects.config_switch_select_n)
        else $error("decoder stayed closed");

    // Both write inputs low must reach the memory
    nvmem_allow_a: assert property (@(posedge clock) disable iff (!rstn) // R9
        !write_strobe_n && !write_permit_n |-> !nvmem_write_n)
        else $error("memory write blocked");

    // Without service the count climbs by one each cycle
    count_step_a: assert property (@(posedge clock) disable iff (!rstn) // R17
        state_q == WD_RUN && !kick && !watchdog_off_switch && count_q != TIMEOUT_LAST
        |=> count_q == $past(count_q) + CW'(1)) else $error("timeout count stalled");

    // Reset pulse holds until its length is used up
    pulse_hold_a: assert property (@(posedge clock) disable iff (!rstn) // R15
        state_q == WD_RESET && pulse_q != PULSE_LAST |=> !processor_reset_n)
        else $error("reset pulse cut short");

    // Reset pulse ends right after its last cycle
    pulse_end_a: assert property (@(posedge clock) disable iff (!rstn) // R15
        state_q == WD_RESET && pulse_q == PULSE_LAST |=> processor_reset_n)
        else $error("reset pulse overran");

endmodule

// ==== tb/cpu_model.sv ====
// Behavioural processor model: multiplexed bus cycles and watchdog service line
module cpu_model (
    input  wire logic       clock,
    output logic      [7:0] ad_in,
    output logic      [7:0] addr_high,
    output logic            latch_gate,
    output logic            program_store_strobe_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic            watchdog_service_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle, every strobe released
    initial begin
        ad_in                  = 8'h00;
        addr_high              = 8'h00;
        latch_gate             = 1'h0;
        program_store_strobe_n = 1'h1;
        read_strobe_n          = 1'h1;
        write_strobe_n         = 1'h1;
        watchdog_service_n     = 1'h1;
    end

    // Address phase, then data phase; strobes stay asserted until idle is called
    task automatic cycle(input logic [15:0] a, input logic rd, input logic wr);
        @(negedge clock);
        addr_high  = a[15:8];
        ad_in      = a[7:0];
        latch_gate = 1'h1;
        @(negedge clock);
        latch_gate             = 1'h0;
        // Low byte leaves the bus, so a leaky latch would show the wrong address
        ad_in                  = ~a[7:0];
        program_store_strobe_n = 1'h0;
        read_strobe_n          = ~rd;
        write_strobe_n         = ~wr;
    endtask

    // Release strobes; the bus shows the inverse of its last value, never a stale copy
    task automatic idle();
        @(negedge clock);
        program_store_strobe_n = 1'h1;
        read_strobe_n          = 1'h1;
        write_strobe_n         = 1'h1;
        ad_in                  = ~ad_in;
    endtask

    // Service line level; low for one clock makes the short service pulse
    task automatic service(input logic v);
        @(negedge clock);
        watchdog_service_n = v;
    endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the board control glue and watchdog
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TO    = 20; // Shortened watchdog timeout
    localparam int unsigned PULSE = 3;  // Shortened reset pulse
    logic        clock, rstn, latch_gate, program_store_strobe_n, read_strobe_n;
    logic        write_strobe_n, watchdog_service_n, watchdog_off_switch, write_permit_n;
    logic        ad_oe, nvmem_write_n, watchdog_kick_in, processor_reset_n, run_indicator;
    logic        tone_half_clock, h;
    logic [7:0]  ad_in, addr_high, ad_out, config_switches;
    logic [15:0] address;
    board_glue_pkg::selects_s selects;
    logic [15:0] row_addr [0:16]; // Decode rows: address beside expected selects
    logic [9:0]  row_sel  [0:16];
    int          error_cnt, check_count, cycles, n;

    board_control_glue_watchdog #(.TIMEOUT_CYCLES(TO), .RESET_PULSE_CYC(PULSE), .SW_WIDTH(8))
    dut (.clock, .rstn, .ad_in, .addr_high, .latch_gate, .program_store_strobe_n,
        .read_strobe_n, .write_strobe_n, .ad_out, .ad_oe, .address, .selects, .nvmem_write_n,
        .config_switches, .watchdog_off_switch, .watchdog_service_n, .write_permit_n,
        .watchdog_kick_in, .processor_reset_n, .run_indicator, .tone_half_clock);

    cpu_model cpu (.clock, .ad_in, .addr_high, .latch_gate, .program_store_strobe_n,
        .read_strobe_n, .write_strobe_n, .watchdog_service_n);

    // 200 MHz clock
    initial clock = 1'h0;
    always #2.5 clock = ~clock;

    // Expected selects: one low output per slot 0 to 9, only with strobe and top line asserted
    function automatic logic [9:0] exp_sel(input logic [15:0] a, input logic ps_n);
        logic [9:0] s;
        s = 10'h3ff;
        if (!ps_n && a[15] && a[14:11] < 4'ha) begin
            s[9 - int'(a[14:11])] = 1'h0;
        end
        return s;
    endfunction

    // Compare and count; mismatches reported at once
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Single place where the run ends
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("Timeout: bench stopped");
            complete_run();
        end
    end

    initial begin
        rstn                = 1'h0;
        config_switches     = 8'ha5;
        watchdog_off_switch = 1'h1; // Watchdog off while decode is exercised
        write_permit_n      = 1'h1;
        repeat (3) @(negedge clock);
        check("run indicator in reset", run_indicator, 1'h0);
        check("cpu reset in reset", processor_reset_n, 1'h0);
        rstn = 1'h1;
        $display("Test reset done");
        // Half-rate clock flips on every rising system edge
        for (int i = 0; i < 4; i++) begin
            h = tone_half_clock;
            @(negedge clock);
            check("half clock", tone_half_clock, 1'(~h));
        end
        $display("Test half clock done");
        // Build rows: all sixteen slots with the top line high, one with it low
        for (int i = 0; i < 16; i++) begin
            row_addr[i] = {1'h1, 4'(i), 11'h2a5};
            row_sel[i]  = exp_sel(row_addr[i], 1'h0);
        end
        row_addr[16] = 16'h08a5;
        row_sel[16]  = 10'h3ff;
        for (int i = 0; i < 17; i++) begin
            cpu.cycle(row_addr[i], 1'h0, 1'h0);
            #1;
            check("selects", selects, row_sel[i]);
            check("address", address, row_addr[i]);
            cpu.idle();
            #1;
            check("selects idle", selects, 10'h3ff);
        end
        $display("Test decode done");
        // Switches reach the bus only on a read of the switch slot
        cpu.cycle(16'h88a5, 1'h1, 1'h0);
        #1;
        check("switch drive", ad_oe, 1'h1);
        check("switch value", ad_out, 8'ha5);
        cpu.idle();
        cpu.cycle(16'h88a5, 1'h0, 1'h1);
        #1;
        check("switch drive on write", ad_oe, 1'h0);
        cpu.idle();
        cpu.cycle(16'h80a5, 1'h1, 1'h0);
        #1;
        check("switch drive other slot", ad_oe, 1'h0);
        cpu.idle();
        $display("Test switches done");
        // Memory write needs both write strobe and permit low
        for (int i = 0; i < 4; i++) begin
            cpu.cycle(16'hc8a5, 1'h0, i[1]);
            write_permit_n = i[0];
            #1;
            check("nvmem write", nvmem_write_n, 1'(~i[1] | i[0]));
            cpu.idle();
        end
        $display("Test memory write done");
        // Disabled watchdog ignores service and never resets
        cpu.service(1'h0);
        #1;
        check("kick while off", watchdog_kick_in, 1'h0);
        cpu.service(1'h1);
        n = 0;
        repeat (60) @(negedge clock) if (processor_reset_n !== 1'h1) n++;
        check("resets while off", 16'(n), 16'h0000);
        // Enabled: service inside the timeout keeps the processor running
        watchdog_off_switch = 1'h0;
        n = 0;
        repeat (6) begin
            repeat (12) @(negedge clock) if (processor_reset_n !== 1'h1) n++;
            cpu.service(1'h0);
            #1;
            check("kick while on", watchdog_kick_in, 1'h1);
            cpu.service(1'h1);
        end
        check("resets while serviced", 16'(n), 16'h0000);
        // Silence: expiry after the full count from the last service edge
        n = 0;
        while (processor_reset_n === 1'h1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("timeout edges", 16'(n), 16'(TO));
        check("run indicator off", run_indicator, 1'h0);
        n = 0;
        while (processor_reset_n === 1'h0 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("reset pulse length", 16'(n), 16'(PULSE));
        check("run indicator on", run_indicator, 1'h1);
        $display("Test watchdog done");
        // Mid-run reset: indicator dark and half clock cleared, clean restart after
        @(negedge clock);
        rstn = 1'h0;
        #1;
        check("run indicator in mid reset", run_indicator, 1'h0);
        check("half clock in mid reset", tone_half_clock, 1'h0);
        @(negedge clock);
        rstn = 1'h1;
        @(negedge clock);
        check("cpu reset after release", processor_reset_n, 1'h1);
        check("run indicator after release", run_indicator, 1'h1);
        $display("Test mid reset done");
        complete_run();
    end
endmodule
